// File: verilog/vmc_defs.svh
/*
 Offsets, field positions, reset values and fixed counts of the VME master control block.
 Assumes inclusion by bare name from the design files of this block.
*/
`ifndef VMC_DEFS_SVH
`define VMC_DEFS_SVH

// Register offsets
`define VMC_MASTER_CTL_OFS   12'h400
`define VMC_MISC_BUS_CONTROL_OFS     12'h404

// Master control field positions
`define VMC_RETRY_HI         31
`define VMC_RETRY_LO         28
`define VMC_PWREL_HI         27
`define VMC_PWREL_LO         24
`define VMC_REQLVL_HI        23
`define VMC_REQLVL_LO        22
`define VMC_REQPOL_BIT       21
`define VMC_RELPOL_BIT       20
`define VMC_FORCE_BIT        19
`define VMC_ACK_BIT          18
`define VMC_BURST_HI         13
`define VMC_BURST_LO         12
`define VMC_BUSNO_HI         7
`define VMC_BUSNO_LO         0

// Master control reset values
`define VMC_RETRY_RST        4'h8
`define VMC_PWREL_RST        4'h0
`define VMC_REQLVL_RST       2'h3
`define VMC_BURST_RST        2'h0
`define VMC_BUSNO_RST        8'h00

// Misc control: writable bits, write-only bits, reset value
`define VMC_MISC_WMASK       32'hf7dd0000
`define VMC_MISC_WOMASK      32'h00c00000
`define VMC_MISC_RST         32'h31040000

// Fixed counts and codes
`define VMC_RETRY_UNIT_SH    6
`define VMC_PWREL_BASE       13'h0080
`define VMC_PWREL_MAXCODE    4'h5
`define VMC_PWREL_EVERY      4'hf
`define VMC_DMA_WATERMARK    8'h80

`endif

// File: verilog/vmc_pkg.sv
/*
 Types of the VME master control block.
 Assumes the defs header for all numeric constants.
*/
`default_nettype none

package vmc_pkg;

    typedef struct packed {
        logic [3:0] retry_limit;
        logic [3:0] posted_write_release_count;
        logic [1:0] bus_request_level;
        logic       bus_request_policy;
        logic       bus_release_policy;
        logic [1:0] aligned_burst_size;
        logic [7:0] bus_number;
    } vmc_ctl_type;

    typedef struct packed {
        logic [1:0] level;
        logic       fair;
        logic       release_on_request;
    } vmc_req_cfg_type;

    typedef enum logic [2:0] {
        OWN_IDLE    = 3'b001,
        OWN_ACQUIRE = 3'b010,
        OWN_HELD    = 3'b100
    } vmc_own_state_type;

endpackage : vmc_pkg
`default_nettype wire

// File: verilog/vmc_retry_counter.sv
/*
 Counts target retries of the current PCI master transfer against a limit.
 Assumes retry and done pulses are single-cycle and synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "vmc_defs.svh"

module vmc_retry_counter (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Limit code
    input  wire logic [3:0] limit_code,
    // Transfer events
    input  wire logic       retry_seen,
    input  wire logic       xfer_done,
    // Result
    output logic            limit_hit
);

    logic [9:0] count_q;
    logic [9:0] limit;

    assign limit = {limit_code, 6'h00};

    always_ff @(posedge clk) begin
        if (reset || xfer_done) begin
            count_q   <= 10'h000;
            limit_hit <= 1'b0;
        end else if (retry_seen && limit_code != 4'h0 && (count_q + 10'h001) == limit) begin
            count_q   <= 10'h000; // R1
            limit_hit <= 1'b1;
        end else begin
            limit_hit <= 1'b0;
            if (retry_seen && limit_code != 4'h0) begin
                count_q <= count_q + 10'h001;
            end
        end
    end

    a_retry_hit_count: assert property (@(posedge clk) disable iff (reset) // R1
        limit_hit |-> $past(limit_code) != 4'h0 && $past(count_q) == $past(limit) - 10'h001)
        else $error("retry limit hit at wrong count");

endmodule : vmc_retry_counter
`default_nettype wire

// File: verilog/vmc_master_ctl.sv
/*
 VME master control: control registers, forced bus ownership, early bus-busy
 release for posted writes, PCI burst watermarks and configuration cycle type.
 Assumes all event inputs are single-cycle pulses synchronous to clk and that
 the register port is driven by the bridge's internal register decoder.
*/
`timescale 1ns/10ps
`default_nettype none
`include "vmc_defs.svh"

// How it works
// R1 - Retry limit code times 64, zero never
// R2 - Release count codes select 128 to 4096 bytes
// R3 - Drop bus busy after programmed posted bytes
// R4 - Code 1111 releases after every transaction
// R5 - Request level and demand or fair policy
// R6 - Release when done or on request
// R7 - Force bit acquires and holds bus busy
// R8 - Forced hold leaves target channel untouched
// R9 - No early release under forced ownership
// R10 - Acknowledge reads one only while held
// R11 - Software polls acknowledge zero before forcing
// R12 - Software drops force after bus error
// R13 - VME masters never set the force bit
// R14 - Burst size sets PCI split boundary
// R15 - Slave watermark from burst, DMA fixed
// R16 - Bus number match gives Type 0
module vmc_master_ctl (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // Register port
    input  wire logic [11:0]            reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [31:0]            reg_wdata,
    output logic [31:0]                 reg_rdata,
    // PCI master retry tracking
    input  wire logic                   pci_retry_seen,
    input  wire logic                   pci_xfer_done,
    output logic                        pci_retry_error,
    // VMEbus arbitration
    input  wire logic                   vme_grant,
    output logic                        vme_force_request,
    output logic                        vme_force_busy,
    output vmc_pkg::vmc_req_cfg_type    vme_req_cfg,
    // Posted write drain
    input  wire logic                   pw_draining,
    input  wire logic                   pw_bytes_valid,
    input  wire logic [3:0]             pw_bytes,
    input  wire logic                   vme_txn_end,
    output logic                        vme_early_release,
    // PCI burst control
    input  wire logic [7:0]             vs_fifo_bytes,
    input  wire logic [7:0]             dma_fifo_bytes,
    output logic [7:0]                  pci_burst_boundary,
    output logic                        vs_pci_request,
    output logic                        dma_pci_request,
    // Configuration cycle mapping
    input  wire logic                   cfg_map_valid,
    input  wire logic [23:16]           cfg_vme_addr,
    output logic                        cfg_type_valid,
    output logic                        cfg_type1
);

    vmc_pkg::vmc_ctl_type       ctl_q;
    vmc_pkg::vmc_own_state_type own_q;
    logic [31:0]                misc_q;
    logic                       force_q;
    logic [12:0]                pw_acc_q;
    logic [12:0]                pw_acc_sum;
    logic [12:0]                pw_limit;
    logic                       own_active;
    logic                       wr_master;
    logic                       wr_misc;

    // Burst size in bytes; reserved code falls back to the smallest
    function automatic logic [7:0] burst_bytes(input logic [1:0] code);
        case (code)
            2'h1:    burst_bytes = 8'h40;
            2'h2:    burst_bytes = 8'h80;
            default: burst_bytes = 8'h20;
        endcase
    endfunction : burst_bytes

    // Release byte count; zero for reserved and per-transaction codes
    function automatic logic [12:0] release_bytes(input logic [3:0] code);
        if (code <= `VMC_PWREL_MAXCODE) begin
            release_bytes = `VMC_PWREL_BASE << code[2:0];
        end else begin
            release_bytes = 13'h0000;
        end
    endfunction : release_bytes

    assign wr_master  = reg_wr && reg_addr == `VMC_MASTER_CTL_OFS;
    assign wr_misc    = reg_wr && reg_addr == `VMC_MISC_BUS_CONTROL_OFS;
    assign own_active = own_q != vmc_pkg::OWN_IDLE;

    // Master control fields
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl_q.retry_limit                <= `VMC_RETRY_RST; // R1
            ctl_q.posted_write_release_count <= `VMC_PWREL_RST;
            ctl_q.bus_request_level          <= `VMC_REQLVL_RST; // R5
            ctl_q.bus_request_policy         <= 1'b0;
            ctl_q.bus_release_policy         <= 1'b0;
            ctl_q.aligned_burst_size         <= `VMC_BURST_RST;
            ctl_q.bus_number                 <= `VMC_BUSNO_RST; // R16
        end else if (wr_master) begin
            ctl_q.retry_limit                <= reg_wdata[`VMC_RETRY_HI:`VMC_RETRY_LO];
            ctl_q.posted_write_release_count <= reg_wdata[`VMC_PWREL_HI:`VMC_PWREL_LO]; // R2
            ctl_q.bus_request_level          <= reg_wdata[`VMC_REQLVL_HI:`VMC_REQLVL_LO];
            ctl_q.bus_request_policy         <= reg_wdata[`VMC_REQPOL_BIT];
            ctl_q.bus_release_policy         <= reg_wdata[`VMC_RELPOL_BIT];
            ctl_q.aligned_burst_size         <= reg_wdata[`VMC_BURST_HI:`VMC_BURST_LO];
            ctl_q.bus_number                 <= reg_wdata[`VMC_BUSNO_HI:`VMC_BUSNO_LO];
        end
    end

    // Force bit follows every write of the master control word
    always_ff @(posedge clk) begin
        if (reset) begin
            force_q <= 1'b0;
        end else if (wr_master) begin
            force_q <= reg_wdata[`VMC_FORCE_BIT]; // R7
        end
    end

    // Misc control is stored only; write-only bits never stick
    always_ff @(posedge clk) begin
        if (reset) begin
            misc_q <= `VMC_MISC_RST;
        end else if (wr_misc) begin
            misc_q <= reg_wdata & `VMC_MISC_WMASK & ~`VMC_MISC_WOMASK;
        end
    end

    // Read data, one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `VMC_MASTER_CTL_OFS: begin
                    reg_rdata <= 32'h00000000;
                    reg_rdata[`VMC_RETRY_HI:`VMC_RETRY_LO]   <= ctl_q.retry_limit;
                    reg_rdata[`VMC_PWREL_HI:`VMC_PWREL_LO]   <= ctl_q.posted_write_release_count;
                    reg_rdata[`VMC_REQLVL_HI:`VMC_REQLVL_LO] <= ctl_q.bus_request_level;
                    reg_rdata[`VMC_REQPOL_BIT]               <= ctl_q.bus_request_policy;
                    reg_rdata[`VMC_RELPOL_BIT]               <= ctl_q.bus_release_policy;
                    reg_rdata[`VMC_ACK_BIT]                  <= own_q == vmc_pkg::OWN_HELD; // R10
                    reg_rdata[`VMC_BURST_HI:`VMC_BURST_LO]   <= ctl_q.aligned_burst_size;
                    reg_rdata[`VMC_BUSNO_HI:`VMC_BUSNO_LO]   <= ctl_q.bus_number;
                end
                `VMC_MISC_BUS_CONTROL_OFS: begin
                    reg_rdata <= misc_q;
                end
                default: begin
                    reg_rdata <= 32'h00000000;
                end
            endcase
        end
    end

    // Forced ownership: request, wait for grant, hold until force drops
    always_ff @(posedge clk) begin
        if (reset) begin
            own_q <= vmc_pkg::OWN_IDLE;
        end else begin
            case (own_q)
                vmc_pkg::OWN_IDLE: begin
                    if (force_q) begin
                        own_q <= vmc_pkg::OWN_ACQUIRE; // R7
                    end
                end
                vmc_pkg::OWN_ACQUIRE: begin
                    if (!force_q) begin
                        own_q <= vmc_pkg::OWN_IDLE;
                    end else if (vme_grant) begin
                        own_q <= vmc_pkg::OWN_HELD;
                    end
                end
                vmc_pkg::OWN_HELD: begin
                    if (!force_q) begin
                        own_q <= vmc_pkg::OWN_IDLE; // R12
                    end
                end
                default: begin
                    own_q <= vmc_pkg::OWN_IDLE;
                end
            endcase
        end
    end

    assign vme_force_request = own_q == vmc_pkg::OWN_ACQUIRE;
    assign vme_force_busy    = own_q == vmc_pkg::OWN_HELD; // R7

    // Arbitration settings registered from the fields, one cycle behind them
    always_ff @(posedge clk) begin
        if (reset) begin
            vme_req_cfg <= '{level: `VMC_REQLVL_RST, fair: 1'b0, release_on_request: 1'b0};
        end else begin
            vme_req_cfg.level              <= ctl_q.bus_request_level; // R5
            vme_req_cfg.fair               <= ctl_q.bus_request_policy;
            vme_req_cfg.release_on_request <= ctl_q.bus_release_policy; // R6
        end
    end

    // Posted write byte count; keeps running under forced hold so
    // the target channel drain is not held up
    assign pw_acc_sum = pw_acc_q + {9'h000, pw_bytes};
    assign pw_limit   = release_bytes(ctl_q.posted_write_release_count); // R2

    always_ff @(posedge clk) begin
        if (reset || !pw_draining) begin
            pw_acc_q <= 13'h0000;
        end else if (pw_bytes_valid) begin
            if (pw_limit != 13'h0000 && pw_acc_sum >= pw_limit) begin
                pw_acc_q <= 13'h0000;
            end else begin
                pw_acc_q <= pw_acc_sum; // R8
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            vme_early_release <= 1'b0;
        end else if (own_active) begin
            vme_early_release <= 1'b0; // R9
        end else if (ctl_q.posted_write_release_count == `VMC_PWREL_EVERY) begin
            vme_early_release <= pw_draining && vme_txn_end; // R4
        end else begin
            vme_early_release <= pw_draining && pw_bytes_valid && pw_limit != 13'h0000
                                 && pw_acc_sum >= pw_limit; // R3
        end
    end

    // PCI burst boundary and bus request watermarks
    always_ff @(posedge clk) begin
        if (reset) begin
            pci_burst_boundary <= 8'h20;
            vs_pci_request     <= 1'b0;
            dma_pci_request    <= 1'b0;
        end else begin
            pci_burst_boundary <= burst_bytes(ctl_q.aligned_burst_size); // R14
            vs_pci_request     <= vs_fifo_bytes >= burst_bytes(ctl_q.aligned_burst_size); // R15
            dma_pci_request    <= dma_fifo_bytes >= `VMC_DMA_WATERMARK; // R15
        end
    end

    // Configuration cycle type
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_type_valid <= 1'b0;
            cfg_type1      <= 1'b0;
        end else begin
            cfg_type_valid <= cfg_map_valid;
            if (cfg_map_valid) begin
                cfg_type1 <= cfg_vme_addr != ctl_q.bus_number; // R16
            end
        end
    end

    vmc_retry_counter vmc_retry_counter_i (
        .clk        (clk),
        .reset      (reset),
        .limit_code (ctl_q.retry_limit),
        .retry_seen (pci_retry_seen),
        .xfer_done  (pci_xfer_done),
        .limit_hit  (pci_retry_error)
    );

    a_force_acquires: assert property (@(posedge clk) disable iff (reset) // R7
        own_q == vmc_pkg::OWN_IDLE && force_q |=> vme_force_request)
        else $error("force bit did not start bus request");

    a_force_release: assert property (@(posedge clk) disable iff (reset) // R7
        vme_force_busy && !force_q |=> !vme_force_busy)
        else $error("bus busy kept after force cleared");

    a_held_needs_grant: assert property (@(posedge clk) disable iff (reset) // R10
        $rose(vme_force_busy) |-> $past(vme_grant) && $past(force_q))
        else $error("held without grant");

    a_no_early_forced: assert property (@(posedge clk) disable iff (reset) // R9
        $past(own_active) |-> !vme_early_release)
        else $error("early release under forced ownership");

    a_every_txn: assert property (@(posedge clk) disable iff (reset) // R4
        !own_active && ctl_q.posted_write_release_count == 4'hf && pw_draining && vme_txn_end
        && !wr_master |=> vme_early_release)
        else $error("missing per transaction release");

    a_release_bytes: assert property (@(posedge clk) disable iff (reset) // R3
        vme_early_release && $past(ctl_q.posted_write_release_count) != 4'hf
        |-> $past(pw_acc_sum) >= $past(pw_limit) && $past(pw_limit) >= 13'h0080)
        else $error("early release before byte count");

    a_dma_watermark: assert property (@(posedge clk) disable iff (reset) // R15
        dma_fifo_bytes == 8'h7f |=> !dma_pci_request)
        else $error("dma request below 128 bytes");

    a_cfg_type: assert property (@(posedge clk) disable iff (reset) // R16
        cfg_map_valid && !wr_master
        |=> cfg_type_valid && cfg_type1 == ($past(cfg_vme_addr) != ctl_q.bus_number))
        else $error("wrong configuration cycle type");

    a_boundary_size: assert property (@(posedge clk) disable iff (reset) // R14
        ctl_q.aligned_burst_size == 2'h2 && !wr_master |=> pci_burst_boundary == 8'h80)
        else $error("burst boundary not 128");

endmodule : vmc_master_ctl
`default_nettype wire

// File: tb/vmc_arbiter_model.sv
/*
 Behavioural VMEbus arbiter for the master control bench.
 Assumes request and busy come from the device, slow from the bench.
*/
`timescale 1ns/10ps
`default_nettype none

module vmc_arbiter_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Arbitration
    input  wire logic request,
    input  wire logic busy,
    input  wire logic slow,
    output logic      grant
);
    logic [3:0] wait_q;

    // Grant after a short or long wait, kept while the device holds the bus
    always_ff @(posedge clk) begin
        if (reset || !(request || busy)) begin
            wait_q <= 4'h0;
            grant  <= 1'b0;
        end else if (!grant) begin
            wait_q <= wait_q + 4'h1;
            grant  <= wait_q >= (slow ? 4'h7 : 4'h0);
        end
    end
endmodule : vmc_arbiter_model

`default_nettype wire

// File: tb/vmc_master_ctl_bench.sv
/*
 Self-checking bench of the VME master control block.
 Assumes the design's register port, event pulses and the arbiter model.
*/
`timescale 1ns/10ps
`default_nettype none

module vmc_master_ctl_bench;
    logic                     clk = 1'b0;
    logic                     reset = 1'b1;
    logic [11:0]              reg_addr = 12'h000;
    logic                     reg_wr = 1'b0;
    logic                     reg_rd = 1'b0;
    logic [31:0]              reg_wdata = 32'h0;
    logic [31:0]              reg_rdata;
    logic                     pci_retry_seen = 1'b0;
    logic                     pci_xfer_done = 1'b0;
    logic                     pci_retry_error;
    logic                     vme_grant;
    logic                     vme_force_request;
    logic                     vme_force_busy;
    vmc_pkg::vmc_req_cfg_type vme_req_cfg;
    logic                     pw_draining = 1'b0;
    logic                     pw_bytes_valid = 1'b0;
    logic [3:0]               pw_bytes = 4'h8;
    logic                     vme_txn_end = 1'b0;
    logic                     vme_early_release;
    logic [7:0]               vs_fifo_bytes = 8'h00;
    logic [7:0]               dma_fifo_bytes = 8'h00;
    logic [7:0]               pci_burst_boundary;
    logic                     vs_pci_request;
    logic                     dma_pci_request;
    logic                     cfg_map_valid = 1'b0;
    logic [7:0]               cfg_vme_addr = 8'h00;
    logic                     cfg_type_valid;
    logic                     cfg_type1;
    logic                     arb_slow = 1'b0;
    logic [31:0]              ctl;
    logic [31:0]              rd;
    logic [7:0]               bnd;
    int                       err_total = 0;
    int                       cmp_count = 0;
    int                       cycles = 0;

    vmc_master_ctl vmc_master_ctl_i (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pci_retry_seen(pci_retry_seen),
        .pci_xfer_done(pci_xfer_done), .pci_retry_error(pci_retry_error), .vme_grant(vme_grant),
        .vme_force_request(vme_force_request), .vme_force_busy(vme_force_busy), .vme_req_cfg(vme_req_cfg),
        .pw_draining(pw_draining), .pw_bytes_valid(pw_bytes_valid), .pw_bytes(pw_bytes),
        .vme_txn_end(vme_txn_end), .vme_early_release(vme_early_release), .vs_fifo_bytes(vs_fifo_bytes),
        .dma_fifo_bytes(dma_fifo_bytes), .pci_burst_boundary(pci_burst_boundary),
        .vs_pci_request(vs_pci_request), .dma_pci_request(dma_pci_request), .cfg_map_valid(cfg_map_valid),
        .cfg_vme_addr(cfg_vme_addr), .cfg_type_valid(cfg_type_valid), .cfg_type1(cfg_type1)
    );

    vmc_arbiter_model vmc_arbiter_model_i (
        .clk(clk), .reset(reset), .request(vme_force_request), .busy(vme_force_busy),
        .slow(arb_slow), .grant(vme_grant)
    );

    always #25 clk = ~clk;

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    task automatic read_check(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        reg_read(a, d);
        check(d, exp);
    endtask : read_check

    // Kind 0 retries, 1 posted beats of pw_bytes bytes, 2 transaction ends
    task automatic beats(input int kind, input int n, input logic hit);
        for (int i = 0; i <= n; i++) begin
            @(posedge clk);
            pci_retry_seen <= kind == 0 && i < n;
            pw_bytes_valid <= kind == 1 && i < n;
            vme_txn_end    <= kind == 2 && i < n;
            #1 check(kind == 0 ? pci_retry_error : vme_early_release, hit && i == n);
        end
    endtask : beats

    task automatic retry_case(input logic [3:0] code, input int n, input logic hit);
        ctl[31:28] = code;
        reg_write(12'h400, ctl);
        pci_xfer_done <= 1'b1;
        @(posedge clk);
        pci_xfer_done <= 1'b0;
        beats(0, n, hit);
    endtask : retry_case

    task automatic pw_case(input logic [3:0] code, input int kind, input int n, input logic hit);
        ctl[27:24] = code;
        reg_write(12'h400, ctl);
        pw_draining <= 1'b0;
        @(posedge clk);
        pw_draining <= 1'b1;
        beats(kind, n, hit);
    endtask : pw_case

    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1 check(vme_req_cfg, 4'b1100);
        read_check(12'h400, 32'h80c00000);
        read_check(12'h404, 32'h31040000);
        read_check(12'h408, 32'h0);
        reg_write(12'h404, 32'hffffffff);
        read_check(12'h404, 32'hf71d0000);
        // Every level, policy and burst code
        for (int l = 0; l < 4; l++) begin
            ctl = {4'h1, 4'h0, l[1:0], l[0], l[1], 6'h0, l[1:0], 4'h0, 8'h00};
            reg_write(12'h400, ctl);
            bnd = l == 1 ? 8'h40 : l == 2 ? 8'h80 : 8'h20;
            vs_fifo_bytes  <= bnd - 8'h01;
            dma_fifo_bytes <= 8'h7f;
            read_check(12'h400, ctl);
            check(vme_req_cfg, {l[1:0], l[0], l[1]});
            check(pci_burst_boundary, bnd);
            check({vs_pci_request, dma_pci_request}, 2'b00);
            @(posedge clk);
            vs_fifo_bytes  <= bnd;
            dma_fifo_bytes <= 8'h80;
            repeat (2) @(posedge clk);
            #1 check({vs_pci_request, dma_pci_request}, 2'b11);
        end
        ctl[7:0] = 8'h5a;
        reg_write(12'h400, ctl);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            cfg_map_valid <= 1'b1;
            cfg_vme_addr  <= 8'h5a + k[7:0];
            @(posedge clk);
            cfg_map_valid <= 1'b0;
            #1 check({cfg_type_valid, cfg_type1}, {1'b1, k[0]});
        end
        retry_case(4'h1, 64, 1'b1);
        retry_case(4'h2, 128, 1'b1);
        retry_case(4'h0, 300, 1'b0);
        for (int c = 0; c < 6; c++)
            pw_case(c[3:0], 1, 16 << c, 1'b1);
        pw_case(4'hf, 2, 1, 1'b1);
        pw_case(4'h6, 1, 16, 1'b0);
        pw_case(4'he, 2, 1, 1'b0);
        ctl[27:24] = 4'h0;
        // Forced ownership against a prompt and a slow arbiter
        for (int s = 0; s < 2; s++) begin
            for (int n = 0; n < 8; n++) begin
                reg_read(12'h400, rd);
                if (rd[18] === 1'b0)
                    break;
            end
            arb_slow <= s[0];
            reg_write(12'h400, ctl | 32'h00080000);
            repeat (2) @(posedge clk);
            #1 check(vme_force_request, 1'b1);
            for (int n = 0; n < 20 && vme_force_busy !== 1'b1; n++)
                @(posedge clk);
            #1 check(vme_force_busy, 1'b1);
            read_check(12'h400, ctl | 32'h00040000);
            beats(1, 16, 1'b0);
            beats(1, 8, 1'b0);
            reg_write(12'h400, ctl | 32'h0f080000);
            beats(2, 1, 1'b0);
            check(vme_force_busy, 1'b1);
            reg_write(12'h400, ctl);
            repeat (2) @(posedge clk);
            #1 check({vme_force_busy, vme_force_request}, 2'b00);
            read_check(12'h400, ctl);
            // Bytes drained while held still count toward the next release
            pw_bytes <= 4'h4;
            beats(1, 16, 1'b1);
            pw_bytes <= 4'h8;
        end
        stop_test();
    end
endmodule : vmc_master_ctl_bench

`default_nettype wire
